// File: bench/tb_uicid_bank.sv
// bench for the clear/ident bank: apb master task and register tests
// assumes the source model drives src_set and the checker is bound
`timescale 1ns/1ps
module tb_uicid_bank;
  localparam logic [31:0] IDENT = 32'ha55a3cc3; // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, b;
  logic [11:0] src_set;
  logic [2:0]  uart_irq;
  int          fail_count = 0, checks_done = 0, cyc = 0;
  uicid_bank #(.PERIPH_IDENT(IDENT)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .src_set, .uart_irq, .irq);
  uicid_src_model src (.pclk, .src_set);
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // for reads d is the expected word
  task automatic acc(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'h1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    if (!w) chk("prdata", d, prdata);
    chk("pslverr", {31'h0, a[31:12] > 20'h4000e}, {31'h0, pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      b = 32'h4000c000 + 32'(i) * 32'h1000;
      for (int k = 0; k < 4; k++) begin
        acc(1'h1, b + 32'hfd0 + 32'(4 * k), 32'hffffffff);
        acc(1'h0, b + 32'hfd0 + 32'(4 * k), {24'h0, IDENT[k*8 +: 8]});
      end
      acc(1'h0, b + 32'h044, 32'h0);
      acc(1'h1, b + 32'h038, 32'hf0);
      src.pulse(i, 4'hf);
      for (int k = 7; k > 3; k--) begin
        acc(1'h0, b + 32'h040, (32'h1 << (k + 1)) - 32'h10);
        chk("uart_irq", 32'h1, {31'h0, uart_irq[i]});
        acc(1'h1, b + 32'h044, (32'h1 << k) | 32'h0f);
        acc(1'h0, b + 32'h03c, (32'h1 << k) - 32'h10);
      end
      chk("uart_irq", 32'h0, {31'h0, uart_irq[i]});
    end
    src.pulse(0, 4'hf);
    acc(1'h1, 32'h4000c044, 32'h0f);
    acc(1'h0, 32'h4000c03c, 32'hf0);
    acc(1'h1, 32'h4000c044, 32'hf0);
    acc(1'h0, 32'h4000c03c, 32'h0);
    // every instance saw an ident write above
    acc(1'h1, 32'h4000c054, 32'h7);
    acc(1'h0, 32'h4000c050, 32'h7);
    chk("irq", 32'h1, {31'h0, irq});
    acc(1'h1, 32'h4000c058, 32'h7);
    acc(1'h0, 32'h4000c050, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    acc(1'h0, 32'h4000f000, 32'h0);
    stop_test();
  end
endmodule

// File: bench/uicid_bank_asserts.sv
// checker for the clear/ident bank, bound to its apb and irq ports
// assumes one apb master and instance 0 at the first window
`timescale 1ns/1ps
module uicid_bank_asserts #(parameter logic [31:0] PERIPH_IDENT = 32'h0) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // interrupts
  input wire logic [11:0] src_set,
  input wire logic [2:0]  uart_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  logic win;
  logic clr0;
  assign rd_ok = pready && !pwrite && win;
  assign win = paddr[31:12] inside {20'h4000c, 20'h4000d, 20'h4000e};
  // a set pulse in the clear cycle wins, so only quiet cycles are judged
  assign clr0 = psel && penable && !pready && pwrite && paddr == 32'h4000c044
    && src_set[3:0] == 4'h0;
  rdy_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("pready held");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  win_err_a: assert property (pready |-> pslverr == !win)
    else $error("window error");
  id_word_a: assert property (rd_ok && paddr[11:4] == 8'hfd |->
    prdata == {24'h0, PERIPH_IDENT[paddr[3:2]*8 +: 8]}) else $error("ident word");
  clr_read_a: assert property (rd_ok && paddr[11:0] == 12'h044 |-> prdata == 32'h0)
    else $error("clear reads back");
  clr_all_a: assert property (clr0 && pwdata[7:4] == 4'hf |-> ##2 !uart_irq[0])
    else $error("clear missed");
  clr_keep_a: assert property (clr0 && pwdata[7:4] == 4'h0 && uart_irq[0] |-> ##2 uart_irq[0])
    else $error("zero cleared");
endmodule
bind uicid_bank uicid_bank_asserts #(.PERIPH_IDENT(PERIPH_IDENT)) chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .src_set, .uart_irq);

// File: bench/uicid_src_model.sv
// partner model: datapath side that raises interrupt source pulses
// assumes pulses are asked for between apb transfers
`timescale 1ns/1ps
module uicid_src_model (
  // clock
  input wire logic  pclk,
  // source pulses, fe rt tx rx per instance
  output logic [11:0] src_set
);
  initial src_set = 12'h000;
  task automatic pulse(input int i, input logic [3:0] s);
    @(posedge pclk);
    src_set[i*4 +: 4] <= s;
    @(posedge pclk);
    src_set <= 12'h000;
  endtask
endmodule

// File: src/uicid_bank.sv
// interrupt clear and peripheral identifier bank for three serial port instances
// assumes one apb master; each instance has four raw interrupt sources from its datapath
`timescale 1ns/1ps
`include "uicid_params.svh"

module uicid_bank #(
  parameter int          NUM_INST   = 3,
  // identifier value is arbitrary, not a real part code
  parameter logic [31:0] PERIPH_IDENT = `UICID_ID_DEFAULT
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // interrupt sources, one-cycle set pulses per instance, bits fe rt tx rx
  input  wire logic [11:0] src_set,
  // per-instance masked interrupt lines
  output logic [2:0]       uart_irq,
  // bank event interrupt
  output logic             irq
);

  // the decoder and the event register are sized for exactly three windows
  if (NUM_INST != 3) begin : g_inst_check
    $error("uicid_bank serves exactly three instances");
  end

  localparam logic [31:0] BASES [3] = '{`UICID_BASE_0, `UICID_BASE_1, `UICID_BASE_2};

  uicid_pkg::uicid_req_s   req;
  uicid_pkg::uicid_state_e state_q;
  uicid_pkg::uicid_state_e state_d;

  logic [3:0]  raw_q  [3];
  logic [3:0]  mask_q [3];
  logic [2:0]  evt_stat_q;
  logic [2:0]  evt_en_q;
  logic [2:0]  hit;
  logic [1:0]  sel_inst;
  logic [11:0] off;
  logic        decoded;
  logic        wr_fire;
  logic [31:0] rdata_d;
  logic [2:0]  clr_evt;

  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign off       = req.addr[11:0];

  // each instance owns a 4 KiB window at its base
  always_comb begin
    hit      = 3'b000;
    sel_inst = 2'd0;
    for (int i = 0; i < 3; i++) begin
      if ((req.addr & `UICID_WIN_MASK) == BASES[i]) begin
        hit[i]   = 1'b1;
        sel_inst = 2'(i);
      end
    end
  end

  assign decoded = |hit;

  // one wait state: setup, access, then ready at the following edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uicid_pkg::UICID_IDLE:   if (psel && !penable) state_d = uicid_pkg::UICID_ACCESS;
      uicid_pkg::UICID_ACCESS: if (psel && penable) state_d = uicid_pkg::UICID_DONE;
      uicid_pkg::UICID_DONE:   state_d = uicid_pkg::UICID_IDLE;
      default:                 state_d = uicid_pkg::UICID_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= uicid_pkg::UICID_IDLE;
    else          state_q <= state_d;
  end

  assign wr_fire = (state_q == uicid_pkg::UICID_ACCESS) && psel && penable && req.write;

  // raw status per instance; a set pulse beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) raw_q[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_fire && hit[i] && off == `UICID_OFF_ICLR) begin
          raw_q[i] <= (raw_q[i] & ~req.wdata[`UICID_SRC_MSB:`UICID_SRC_LSB])
                      | src_set[i*4 +: 4];
        end else begin
          raw_q[i] <= raw_q[i] | src_set[i*4 +: 4];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) mask_q[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_fire && hit[i] && off == `UICID_OFF_IMSK)
          mask_q[i] <= req.wdata[`UICID_SRC_MSB:`UICID_SRC_LSB];
      end
    end
  end

  // masked line is registered from raw and mask, so it drops one cycle after a clear drops raw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uart_irq <= 3'b000;
    else begin
      for (int i = 0; i < 3; i++) uart_irq[i] <= |(raw_q[i] & mask_q[i]);
    end
  end

  // bank event: a write to an identifier word, which is otherwise ignored
  assign clr_evt = (wr_fire && decoded && off == `UICID_OFF_IEVT_CLR) ?
                   req.wdata[2:0] : 3'b000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_stat_q <= 3'b000;
    else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_fire && hit[i] && off >= `UICID_OFF_ID0 && off <= `UICID_OFF_ID3)
          evt_stat_q[i] <= 1'b1;
        else if (clr_evt[i])
          evt_stat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_en_q <= 3'b000;
    else if (wr_fire && decoded && off == `UICID_OFF_IEVT_EN) evt_en_q <= req.wdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= |(evt_stat_q & evt_en_q);
  end

  // read mux
  always_comb begin
    rdata_d = `UICID_RST_WORD;
    unique case (off)
      `UICID_OFF_ICLR:      rdata_d = `UICID_RST_WORD;
      `UICID_OFF_IRAW:      rdata_d = {24'h0, raw_q[sel_inst], 4'h0};
      `UICID_OFF_IMSK:      rdata_d = {24'h0, mask_q[sel_inst], 4'h0};
      `UICID_OFF_IMIS:      rdata_d = {24'h0, raw_q[sel_inst] & mask_q[sel_inst], 4'h0};
      `UICID_OFF_IEVT_STAT: rdata_d = {29'h0, evt_stat_q};
      `UICID_OFF_IEVT_EN:   rdata_d = {29'h0, evt_en_q};
      `UICID_OFF_ID0:       rdata_d = {24'h0, PERIPH_IDENT[7:0]};
      `UICID_OFF_ID1:       rdata_d = {24'h0, PERIPH_IDENT[15:8]};
      `UICID_OFF_ID2:       rdata_d = {24'h0, PERIPH_IDENT[23:16]};
      `UICID_OFF_ID3:       rdata_d = {24'h0, PERIPH_IDENT[31:24]};
      default:              rdata_d = `UICID_RST_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `UICID_RST_WORD;
      pslverr <= 1'b0;
    end else if (state_d == uicid_pkg::UICID_DONE) begin
      pready  <= 1'b1;
      prdata  <= (decoded && !req.write) ? rdata_d : `UICID_RST_WORD;
      // unmapped window answers with an error
      pslverr <= !decoded;
    end else begin
      pready  <= 1'b0;
      prdata  <= `UICID_RST_WORD;
      pslverr <= 1'b0;
    end
  end

endmodule

// File: src/uicid_params.svh
// offsets, field positions, window bases and reset values for the clear/ident bank
// assumes a 32-bit apb bus; offsets are byte addresses inside one instance window
`ifndef UICID_PARAMS_SVH
`define UICID_PARAMS_SVH

`define UICID_OFF_ICLR      12'h044
`define UICID_OFF_IRAW      12'h03c
`define UICID_OFF_IMSK      12'h038
`define UICID_OFF_IMIS      12'h040
`define UICID_OFF_IEVT_STAT 12'h050
`define UICID_OFF_IEVT_EN   12'h054
`define UICID_OFF_IEVT_CLR  12'h058
`define UICID_OFF_ID0       12'hfd0
`define UICID_OFF_ID1       12'hfd4
`define UICID_OFF_ID2       12'hfd8
`define UICID_OFF_ID3       12'hfdc

`define UICID_BIT_FE        7
`define UICID_BIT_RT        6
`define UICID_BIT_TX        5
`define UICID_BIT_RX        4
`define UICID_SRC_LSB       4
`define UICID_SRC_MSB       7

`define UICID_BASE_0        32'h4000c000
`define UICID_BASE_1        32'h4000d000
`define UICID_BASE_2        32'h4000e000
`define UICID_WIN_MASK      32'hfffff000

`define UICID_RST_WORD      32'h00000000
`define UICID_ID_DEFAULT    32'h00000000

`endif

// File: src/uicid_pkg.sv
// types shared by the clear/ident bank
// assumes the params header is included where offsets are needed
package uicid_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } uicid_req_s;

  typedef logic [3:0] uicid_src_t;

  typedef enum logic [2:0] {
    UICID_IDLE   = 3'b001,
    UICID_ACCESS = 3'b010,
    UICID_DONE   = 3'b100
  } uicid_state_e;
endpackage
